// [bss_attr_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module bss_attr_decode (
  input  wire logic            in_shadow,  // cycle hits a covered slice
  input  wire logic            is_write,   // cycle is a write
  input  wire bss_pkg::bss_attr_t attr,    // field of the matched slice
  output logic                 to_dram,    // steer to dram controller
  output logic                 to_link     // steer down io_hub_link
);
  import bss_pkg::*;

  // ----------------------------------------
  // per-direction steering
  // ----------------------------------------
  // outside the window nothing here applies: such cycles are plain memory
  logic dram_hit;  // attribute grants dram for this direction

  always_comb begin
    dram_hit = 1'b0;
    unique case (attr)
      BSS_ATTR_LINK:    dram_hit = 1'b0;
      BSS_ATTR_RD_DRAM: dram_hit = !is_write;
      BSS_ATTR_WR_DRAM: dram_hit = is_write;
      BSS_ATTR_DRAM:    dram_hit = 1'b1;
    endcase
    to_dram = !in_shadow || dram_hit;
    to_link = in_shadow && !dram_hit;
  end

endmodule
`default_nettype wire

// [bss_bios_shadow_steering.sv]
`timescale 1ns/1ps
`default_nettype none
module bss_bios_shadow_steering (
  input  wire logic                         ref_clk,        // 250 MHz core clock
  input  wire logic                         sys_rst,        // synchronous, active high
  // configuration-space access
  input  wire logic                         cfg_wr,         // write strobe, one cycle
  input  wire logic                         cfg_rd,         // read strobe, one cycle
  input  wire logic [bss_pkg::CFG_AW-1:0]   cfg_addr,       // configuration offset
  input  wire logic [bss_pkg::DATA_W-1:0]   cfg_wdata,      // write data
  output logic [bss_pkg::DATA_W-1:0]        cfg_rdata,      // read data, registered
  output logic                              cfg_rd_valid,   // read data valid pulse
  // host memory cycles
  input  wire logic                         mem_valid,      // a cycle is offered
  input  wire logic [bss_pkg::ADDR_W-1:0]   mem_addr,       // cycle address
  input  wire logic                         mem_write,      // 1 write, 0 read
  // steered cycles
  output logic                              fwd_valid,      // steered cycle pulse
  output logic [bss_pkg::ADDR_W-1:0]        fwd_addr,       // address passed on
  output logic                              fwd_write,      // direction passed on
  output logic                              fwd_to_dram,    // goes to dram controller
  output logic                              fwd_to_link,    // goes down io_hub_link
  output logic                              fwd_in_shadow   // hit a covered slice
);
  import bss_pkg::*;

  // ----------------------------------------
  // overview
  // ----------------------------------------
  // three attribute bytes each hold two 2-bit fields, one per 16 KB slice;
  // a host cycle is matched to its slice, the field picks dram or link
  // separately for reads and writes, and the result leaves one edge later
  // limitation: cycles outside d8000-effff are passed on as plain memory,
  // the neighbouring map logic decides their real fate

  // ----------------------------------------
  // attribute registers
  // ----------------------------------------
  logic [DATA_W-1:0] attr_d8000_r;    // shadow_attr_d8000_dffff
  logic [DATA_W-1:0] attr_d8000_nxt;
  logic [DATA_W-1:0] attr_e0000_r;    // shadow_attr_e0000_e7fff
  logic [DATA_W-1:0] attr_e0000_nxt;
  logic [DATA_W-1:0] attr_e8000_r;    // shadow_attr_e8000_effff
  logic [DATA_W-1:0] attr_e8000_nxt;

  // masking on write keeps reserved bits at zero, so reads need no second mask
  // writes to offsets other than the three registers are dropped silently
  always_comb begin
    attr_d8000_nxt = attr_d8000_r;
    attr_e0000_nxt = attr_e0000_r;
    attr_e8000_nxt = attr_e8000_r;
    if (cfg_wr) begin
      unique case (cfg_addr)
        OFF_ATTR_D8000: attr_d8000_nxt = cfg_wdata & ATTR_WMASK;
        OFF_ATTR_E0000: attr_e0000_nxt = cfg_wdata & ATTR_WMASK;
        OFF_ATTR_E8000: attr_e8000_nxt = cfg_wdata & ATTR_WMASK;
        default: begin
          // other offsets belong to neighbouring blocks
        end
      endcase
    end
  end

  // register the attribute state
  // synchronous reset puts every slice back on the link
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      attr_d8000_r <= ATTR_RESET;
      attr_e0000_r <= ATTR_RESET;
      attr_e8000_r <= ATTR_RESET;
    end else begin
      attr_d8000_r <= attr_d8000_nxt;
      attr_e0000_r <= attr_e0000_nxt;
      attr_e8000_r <= attr_e8000_nxt;
    end
  end

  // ----------------------------------------
  // configuration read answer
  // ----------------------------------------
  // the answer is registered so read data never ride a combinational path
  // out of the block; the data hold until the next read
  logic [DATA_W-1:0] rdata_r;     // held read data
  logic [DATA_W-1:0] rdata_nxt;
  logic              rvalid_r;    // one-cycle answer strobe
  logic              rvalid_nxt;

  // a read taken in the same cycle as a write returns the old contents
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = cfg_rd;
    if (cfg_rd) begin
      unique case (cfg_addr)
        OFF_ATTR_D8000: rdata_nxt = attr_d8000_r;
        OFF_ATTR_E0000: rdata_nxt = attr_e0000_r;
        OFF_ATTR_E8000: rdata_nxt = attr_e8000_r;
        default:        rdata_nxt = RDATA_NONE;    // unmapped reads zero
      endcase
    end
  end

  // register the read answer
  // the strobe is cleared by reset so no answer appears out of reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_r  <= RDATA_NONE;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign cfg_rdata    = rdata_r;
  assign cfg_rd_valid = rvalid_r;

  // ----------------------------------------
  // slice match
  // ----------------------------------------
  logic                   in_shadow;  // address lies in d8000-effff
  logic [SLICE_IDX_W-1:0] slice_idx;  // 0..5, one per 16 KB
  bss_attr_t              slice_attr; // field that governs this cycle

  // slice pairs share a register; the low index bit picks the upper field
  // the index comes from the offset into the window, so one subtractor serves;
  // indices 6 and 7 appear for addresses beyond the window and are caught by
  // the range test, never by the field pick
  always_comb begin
    in_shadow  = bss_in_shadow(mem_addr);
    slice_idx  = bss_slice_idx(mem_addr);
    slice_attr = BSS_ATTR_LINK;
    unique case (slice_idx)
      3'h0: slice_attr = bss_field(attr_d8000_r, 1'b0);
      3'h1: slice_attr = bss_field(attr_d8000_r, 1'b1);
      3'h2: slice_attr = bss_field(attr_e0000_r, 1'b0);
      3'h3: slice_attr = bss_field(attr_e0000_r, 1'b1);
      3'h4: slice_attr = bss_field(attr_e8000_r, 1'b0);
      3'h5: slice_attr = bss_field(attr_e8000_r, 1'b1);
      default: begin
        // indices 6 and 7 only occur outside the window
        slice_attr = BSS_ATTR_LINK;
      end
    endcase
  end

  // ----------------------------------------
  // steering decision
  // ----------------------------------------
  // the decode lives in its own module so the four codes sit in one place
  logic to_dram;  // decision for this cycle
  logic to_link;

  bss_attr_decode u_decode (
    .in_shadow (in_shadow),
    .is_write  (mem_write),
    .attr      (slice_attr),
    .to_dram   (to_dram),
    .to_link   (to_link)
  );

  // ----------------------------------------
  // steered cycle output stage
  // ----------------------------------------
  // one register stage: the decision uses the attributes in force on the
  // cycle's own clock edge, so a write to a register steers from the next
  // cycle on; trading a cycle of latency for clean registered outputs
  logic              fv_r;    // steered cycle valid
  logic              fv_nxt;
  logic [ADDR_W-1:0] fa_r;    // passed address
  logic [ADDR_W-1:0] fa_nxt;
  logic              fw_r;    // passed direction
  logic              fw_nxt;
  logic              fd_r;    // dram select
  logic              fd_nxt;
  logic              fl_r;    // link select
  logic              fl_nxt;
  logic              fs_r;    // shadow hit
  logic              fs_nxt;

  // valid and the three steering flags drop to zero between cycles so a
  // downstream consumer never sees a stale target
  // capture on an offered cycle, otherwise hold data and drop valid
  always_comb begin
    fv_nxt = mem_valid;
    fa_nxt = fa_r;
    fw_nxt = fw_r;
    fd_nxt = 1'b0;
    fl_nxt = 1'b0;
    fs_nxt = 1'b0;
    if (mem_valid) begin
      fa_nxt = mem_addr;
      fw_nxt = mem_write;
      fd_nxt = to_dram;
      fl_nxt = to_link;
      fs_nxt = in_shadow;
    end
  end

  // register the steered cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fv_r <= 1'b0;
      fa_r <= '0;
      fw_r <= 1'b0;
      fd_r <= 1'b0;
      fl_r <= 1'b0;
      fs_r <= 1'b0;
    end else begin
      fv_r <= fv_nxt;
      fa_r <= fa_nxt;
      fw_r <= fw_nxt;
      fd_r <= fd_nxt;
      fl_r <= fl_nxt;
      fs_r <= fs_nxt;
    end
  end

  assign fwd_valid     = fv_r;
  assign fwd_addr      = fa_r;
  assign fwd_write     = fw_r;
  assign fwd_to_dram   = fd_r;
  assign fwd_to_link   = fl_r;
  assign fwd_in_shadow = fs_r;

endmodule
`default_nettype wire

// [bss_bios_shadow_steering_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module bss_bios_shadow_steering_tb_top;
  import bss_pkg::*;
  logic              ref_clk, sys_rst, cfg_wr, cfg_rd, cfg_rd_valid, mem_valid, mem_write;
  logic              fwd_valid, fwd_write, fwd_to_dram, fwd_to_link, fwd_in_shadow;
  logic [CFG_AW-1:0] cfg_addr;
  logic [DATA_W-1:0] cfg_wdata, cfg_rdata, d;
  logic [ADDR_W-1:0] mem_addr, fwd_addr, lo;
  logic [1:0]        code_r [6];  // expected field per slice, lowest first
  int                n_fail, n_checks;
  bss_bios_shadow_steering i_dut (.ref_clk, .sys_rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata,
    .cfg_rd_valid, .mem_valid, .mem_addr, .mem_write, .fwd_valid, .fwd_addr, .fwd_write, .fwd_to_dram,
    .fwd_to_link, .fwd_in_shadow);
  bss_host_model i_host (.ref_clk, .mem_valid, .mem_addr, .mem_write);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] wd);
    @(negedge ref_clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = wd;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
  endtask
  // answer comes exactly one edge after the strobe
  task automatic cfg_read(input logic [7:0] a, output logic [7:0] rd);
    @(negedge ref_clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    chk(32'(cfg_rd_valid), 32'h1);
    rd = cfg_rdata;
  endtask
  // judge the steered cycle now standing on the outputs
  task automatic fwd_chk(input logic [31:0] a, input logic w);
    logic hit;
    logic [2:0] s;
    logic [1:0] c;
    logic dr;
    hit = (a >= 32'h000d8000) && (a <= 32'h000effff);
    s = 3'((a - 32'h000d8000) >> 14);
    c = hit ? code_r[s] : 2'b00;
    dr = !hit || (w ? c[1] : c[0]);
    chk(32'({fwd_valid, fwd_in_shadow, fwd_to_dram, fwd_to_link}), 32'({1'b1, hit, dr, hit && !dr}));
    chk(fwd_addr, a);
    chk(32'(fwd_write), 32'(w));
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    code_r = '{default: 2'b00};
    for (int r = 0; r < 3; r++) begin
      cfg_read(8'(8'h94 + r), d);
      chk(32'(d), 32'h0);
    end
    i_host.offer(32'h000effff, 1'b1);
    i_host.idle();
    fwd_chk(32'h000effff, 1'b1);
  endtask
  // reserved bits drop, unmapped offset reads zero
  task automatic t_reserved();
    for (int r = 0; r < 4; r++) begin
      cfg_write(8'(8'h94 + r), 8'hff);
      cfg_read(8'(8'h94 + r), d);
      chk(32'(d), (r < 3) ? 32'h33 : 32'h0);
    end
  endtask
  // every code on every slice, both ends of each slice, back to back
  task automatic t_codes();
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 6; s++) code_r[s] = 2'(s + k);
      for (int r = 0; r < 3; r++) cfg_write(8'(8'h94 + r), {2'b00, code_r[2*r+1], 2'b00, code_r[2*r]});
      for (int s = 0; s < 6; s++) begin
        lo = 32'h000d8000 + 32'(s) * 32'h4000;
        i_host.offer(lo, 1'b0);
        i_host.offer(lo + 32'h3fff, 1'b1);
        fwd_chk(lo, 1'b0);
        i_host.idle();
        fwd_chk(lo + 32'h3fff, 1'b1);
      end
    end
    i_host.offer(32'h000d7fff, 1'b0);
    i_host.offer(32'h000f0000, 1'b1);
    fwd_chk(32'h000d7fff, 1'b0);
    i_host.idle();
    fwd_chk(32'h000f0000, 1'b1);
  endtask
  // mid-run reset must clear written attributes back to the link
  task automatic t_rerun_reset();
    @(negedge ref_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_reset();
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // hang guard, counted as a mismatch
  initial begin
    #50000;
    n_fail++;
    complete_run();
  end
  initial begin
    {sys_rst, cfg_wr, cfg_rd, cfg_addr, cfg_wdata, n_fail, n_checks} = '0;
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_reset();
    t_reserved();
    t_codes();
    t_rerun_reset();
    complete_run();
  end
endmodule
bind bss_bios_shadow_steering bss_steer_sva i_sva (.ref_clk, .sys_rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata,
  .cfg_rdata, .cfg_rd_valid, .mem_valid, .mem_addr, .mem_write, .fwd_valid, .fwd_addr, .fwd_write,
  .fwd_to_dram, .fwd_to_link, .fwd_in_shadow);
`default_nettype wire

// [bss_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// host side: offers memory cycles, no backpressure exists
module bss_host_model (
  input  wire logic                        ref_clk,
  output logic                             mem_valid,
  output logic [bss_pkg::ADDR_W-1:0]       mem_addr,
  output logic                             mem_write
);
  import bss_pkg::*;
  initial begin
    mem_valid = 1'b0;
    mem_addr = '0;
    mem_write = 1'b0;
  end
  // one cycle per call; calls may chain back to back
  task automatic offer(input logic [ADDR_W-1:0] a, input logic w);
    @(negedge ref_clk);
    mem_valid = 1'b1;
    mem_addr = a;
    mem_write = w;
  endtask
  // released bus shows inverted leftovers, not the last value
  task automatic idle();
    @(negedge ref_clk);
    mem_valid = 1'b0;
    mem_addr = ~mem_addr;
    mem_write = ~mem_write;
  endtask
endmodule
`default_nettype wire

// [bss_pkg.sv]
`default_nettype none
package bss_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int unsigned ADDR_W      = 32;   // host memory address width
  localparam int unsigned CFG_AW      = 8;    // configuration offset width
  localparam int unsigned DATA_W      = 8;    // attribute register width
  localparam int unsigned FIELD_W     = 2;    // one slice attribute field
  localparam int unsigned SLICE_IDX_W = 3;    // index over six slices

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [CFG_AW-1:0] OFF_ATTR_D8000 = 8'h94;  // shadow_attr_d8000_dffff
  localparam logic [CFG_AW-1:0] OFF_ATTR_E0000 = 8'h95;  // shadow_attr_e0000_e7fff
  localparam logic [CFG_AW-1:0] OFF_ATTR_E8000 = 8'h96;  // shadow_attr_e8000_effff
  localparam logic [DATA_W-1:0] ATTR_RESET     = 8'h00;  // all slices to the link
  localparam logic [DATA_W-1:0] ATTR_WMASK     = 8'h33;  // only the two fields store
  localparam logic [DATA_W-1:0] RDATA_NONE     = 8'h00;  // unmapped offsets read zero
  localparam int unsigned       HI_LSB         = 4;      // upper_slice_attr position
  localparam int unsigned       LO_LSB         = 0;      // lower_slice_attr position

  // ----------------------------------------
  // shadow window geometry
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] SHADOW_BASE = 32'h000d8000;  // first covered byte
  localparam logic [ADDR_W-1:0] SHADOW_LAST = 32'h000effff;  // last covered byte
  localparam int unsigned       SLICE_SHIFT = 14;            // 16 KB slices

  // slice attribute codes
  typedef enum logic [FIELD_W-1:0] {
    BSS_ATTR_LINK    = 2'b00,
    BSS_ATTR_RD_DRAM = 2'b01,
    BSS_ATTR_WR_DRAM = 2'b10,
    BSS_ATTR_DRAM    = 2'b11
  } bss_attr_t;

  // address falls inside the covered window
  function automatic logic bss_in_shadow(input logic [ADDR_W-1:0] addr);
    return (addr >= SHADOW_BASE) && (addr <= SHADOW_LAST);
  endfunction

  // slice number 0..5 counted upward from the base
  function automatic logic [SLICE_IDX_W-1:0] bss_slice_idx(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] off;
    off = addr - SHADOW_BASE;
    return off[SLICE_SHIFT +: SLICE_IDX_W];
  endfunction

  // pick the upper or lower field out of a register
  function automatic bss_attr_t bss_field(input logic [DATA_W-1:0] r, input logic hi);
    return hi ? bss_attr_t'(r[HI_LSB +: FIELD_W]) : bss_attr_t'(r[LO_LSB +: FIELD_W]);
  endfunction

endpackage
`default_nettype wire

// [bss_steer_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module bss_steer_sva (
  input wire logic                       ref_clk,
  input wire logic                       sys_rst,
  input wire logic                       cfg_wr,
  input wire logic                       cfg_rd,
  input wire logic [bss_pkg::CFG_AW-1:0] cfg_addr,
  input wire logic [bss_pkg::DATA_W-1:0] cfg_wdata,
  input wire logic [bss_pkg::DATA_W-1:0] cfg_rdata,
  input wire logic                       cfg_rd_valid,
  input wire logic                       mem_valid,
  input wire logic [bss_pkg::ADDR_W-1:0] mem_addr,
  input wire logic                       mem_write,
  input wire logic                       fwd_valid,
  input wire logic [bss_pkg::ADDR_W-1:0] fwd_addr,
  input wire logic                       fwd_write,
  input wire logic                       fwd_to_dram,
  input wire logic                       fwd_to_link,
  input wire logic                       fwd_in_shadow
);
  import bss_pkg::*;
  logic [7:0]  mirror_r [3];  // copy of the three attribute bytes
  logic [31:0] off;           // offset into the window
  logic [7:0]  sel;           // byte covering the addressed slice
  logic [1:0]  code;          // field of the addressed slice
  logic        hit;           // address inside the window
  logic        exp_dram;      // expected dram steering
  logic [7:0]  exp_rd;        // expected read answer
  // ----------------------------------------
  // reference model of the steering
  // ----------------------------------------
  // out-of-window indexes may be x; hit masks them out
  always_comb begin
    off = mem_addr - 32'h000d8000;
    hit = (mem_addr >= 32'h000d8000) && (mem_addr <= 32'h000effff);
    sel = mirror_r[off[16:15]];
    code = off[14] ? sel[5:4] : sel[1:0];
    exp_dram = !hit || (mem_write ? code[1] : code[0]);
    exp_rd = (cfg_addr >= 8'h94 && cfg_addr <= 8'h96) ? mirror_r[cfg_addr[1:0]] : 8'h00;
  end
  // reserved bits never stored
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mirror_r <= '{default: 8'h00};
    end else if (cfg_wr && cfg_addr >= 8'h94 && cfg_addr <= 8'h96) begin
      mirror_r[cfg_addr[1:0]] <= cfg_wdata & 8'h33;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_rd_answer: assert property (cfg_rd |=> cfg_rd_valid && cfg_rdata == $past(exp_rd))
    else $error("read answer wrong");
  chk_rd_quiet: assert property (!cfg_rd |=> !cfg_rd_valid)
    else $error("spurious read valid");
  chk_fwd_pulse: assert property (mem_valid |=> fwd_valid && fwd_addr == $past(mem_addr) && fwd_write == $past(mem_write))
    else $error("steered cycle missing");
  chk_fwd_idle: assert property (!mem_valid |=> !(fwd_valid || fwd_to_dram || fwd_to_link || fwd_in_shadow))
    else $error("steer outputs without cycle");
  chk_one_target: assert property (fwd_valid |-> fwd_to_dram != fwd_to_link)
    else $error("cycle not sent to exactly one target");
  chk_window_hit: assert property (mem_valid |=> fwd_in_shadow == $past(hit))
    else $error("window hit wrong");
  chk_steer_dram: assert property (mem_valid |=> fwd_to_dram == $past(exp_dram))
    else $error("dram steering wrong");
  chk_steer_link: assert property (mem_valid && hit |=> fwd_to_link == !$past(exp_dram))
    else $error("link steering wrong");
endmodule
`default_nettype wire
